// ### hw/debug_config_lower_controls.sv
// Lower control fields of the debug configuration register and trace output
`timescale 1ns/1ps
`include "debug_config_cfg.svh"

// Notes on behaviour
// - Force-emulation bit 13 set makes the core start in emulator mode.
// - Bits 12-11 pick operand capture: none, writes, reads, or both.
// - Operand follows a size mark; 8/16/32 bits, one nibble per tick.
// - Bit 10 clear: halt is supervisor only; set: user may halt too.
// - Bits 9-8 pick branch target bytes shown: 0, 2, 3 or 4.
// - Bit 6 set runs one instruction at a time, five extra cycles.
// - PC breakpoint is always reported before its instruction runs.
// - Data/address triggers are precise in serial mode, before next.
// - Bit 5 set ignores pending interrupts while single-stepping.
// - Bit 4 set halts after each instruction; go runs one more.
// - Supervisor path writes only; debug port reads and writes.

module debug_config_lower_controls
    import debug_config_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // Supervisor write path
    input wire logic sup_wr_in,
    input wire logic [31:0] sup_wdata_in,
    // Background debug port path
    input wire logic bdp_wr_in,
    input wire logic bdp_rd_in,
    input wire logic [31:0] bdp_wdata_in,
    input wire logic bdp_go_in,
    output logic [31:0] bdp_rdata_out,
    // Core status and requests
    input wire logic instr_done_in,
    input wire logic user_mode_in,
    input wire logic halt_instr_in,
    input wire logic irq_pending_in,
    input wire logic pc_bkpt_hit_in,
    input wire logic data_bkpt_hit_in,
    // Core controls
    output logic force_emulator_entry_out,
    output logic serial_execution_mode_out,
    output logic core_halt_out,
    output logic issue_hold_out,
    output logic halt_allowed_out,
    output logic irq_take_out,
    output logic bkpt_report_out,
    // Trace sources
    input wire logic op_valid_in,
    input wire operand_event_t op_event_in,
    output logic op_ready_out,
    input wire logic br_valid_in,
    input wire logic [31:0] br_target_in,
    output logic br_ready_out,
    // Trace pins
    output logic [3:0] trace_data_pins_out,
    output logic processor_status_clock_out
);

    // ==========================================================
    // Register
    // ==========================================================
    logic [31:0] cfg_r;
    logic [31:0] cfg_nxt;

    // Debug port wins when both paths write in one cycle
    assign cfg_nxt = bdp_wr_in ? (bdp_wdata_in & `DBG_CFG_WMASK) :
                     (sup_wdata_in & `DBG_CFG_WMASK);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_r <= `DBG_CFG_RESET;
        end else if (ce_in && (bdp_wr_in || sup_wr_in)) begin
            cfg_r <= cfg_nxt;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bdp_rdata_out <= 32'h0000_0000;
        end else if (ce_in && bdp_rd_in) begin
            bdp_rdata_out <= cfg_r;
        end
    end

    wire logic [1:0] capture_sel = cfg_r[`FLD_CAPTURE_HI:`FLD_CAPTURE_LO];
    wire logic [1:0] branch_sel = cfg_r[`FLD_BRANCH_HI:`FLD_BRANCH_LO];
    wire logic step_on = cfg_r[`FLD_SINGLE_STEP];
    wire logic serial_on = cfg_r[`FLD_SERIAL];

    assign force_emulator_entry_out = cfg_r[`FLD_FORCE_EMU];
    assign serial_execution_mode_out = serial_on;
    assign halt_allowed_out = halt_instr_in &&
        (!user_mode_in || cfg_r[`FLD_USER_HALT]);
    assign irq_take_out = irq_pending_in &&
        !(step_on && cfg_r[`FLD_IRQ_IGNORE]);

    // ==========================================================
    // Single step and serial execution
    // ==========================================================
    logic halt_r;
    logic [2:0] gap_r;
    logic data_pend_r;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            halt_r <= 1'b0;
        end else if (ce_in) begin
            // Completion beats a simultaneous go so no step is lost
            if (step_on && instr_done_in) begin
                halt_r <= 1'b1;
            end else if (bdp_go_in || !step_on) begin
                halt_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            gap_r <= 3'h0;
        end else if (ce_in) begin
            if (serial_on && instr_done_in) begin
                gap_r <= `SERIAL_GAP_CYCLES;
            end else if (gap_r != 3'h0) begin
                gap_r <= gap_r - 3'h1;
            end
        end
    end

    // Serial mode holds issue until a data trigger has been reported
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            data_pend_r <= 1'b0;
        end else if (ce_in) begin
            data_pend_r <= data_bkpt_hit_in && serial_on;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            bkpt_report_out <= 1'b0;
        end else if (ce_in) begin
            bkpt_report_out <= pc_bkpt_hit_in || data_bkpt_hit_in;
        end
    end

    // PC hits stall issue in the same cycle, ahead of execution
    assign core_halt_out = halt_r;
    assign issue_hold_out = halt_r || (gap_r != 3'h0) ||
        pc_bkpt_hit_in || data_pend_r || (serial_on && data_bkpt_hit_in);

    // ==========================================================
    // Trace serializer
    // ==========================================================
    function automatic logic [3:0] branch_nibbles(input logic [1:0] sel);
        case (sel)
            2'h1: branch_nibbles = 4'h4;
            2'h2: branch_nibbles = 4'h6;
            2'h3: branch_nibbles = 4'h8;
            default: branch_nibbles = 4'h0;
        endcase
    endfunction

    function automatic logic [3:0] op_nibbles(input op_size_t sz);
        case (sz)
            SIZE_BYTE: op_nibbles = 4'h2;
            SIZE_WORD: op_nibbles = 4'h4;
            default: op_nibbles = 4'h8;
        endcase
    endfunction

    logic div_r;
    trace_state_t st_r;
    logic [31:0] sh_r;
    logic [3:0] cnt_r;
    logic [3:0] mark_r;

    wire logic pst_tick = (div_r == `PST_DIV);
    wire logic idle = (st_r == TR_IDLE);
    wire logic op_want = capture_sel[0] && op_event_in.is_write ||
        capture_sel[1] && !op_event_in.is_write;
    wire logic op_take = op_valid_in && idle && pst_tick;
    wire logic br_take = br_valid_in && !op_valid_in && idle && pst_tick;
    wire logic [3:0] op_mark = (op_event_in.size == SIZE_BYTE) ?
        `TRACE_MARK_BYTE : (op_event_in.size == SIZE_WORD) ?
        `TRACE_MARK_WORD : `TRACE_MARK_LONG;

    // Sources stall while a transfer is being shown
    assign op_ready_out = idle && pst_tick;
    assign br_ready_out = idle && pst_tick && !op_valid_in;
    assign processor_status_clock_out = div_r;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_r <= 1'b0;
        end else if (ce_in) begin
            div_r <= pst_tick ? 1'b0 : div_r + 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= TR_IDLE;
            sh_r <= 32'h0000_0000;
            cnt_r <= 4'h0;
            mark_r <= 4'h0;
            trace_data_pins_out <= 4'h0;
        end else if (ce_in && pst_tick) begin
            case (st_r)
                TR_IDLE: begin
                    trace_data_pins_out <= 4'h0;
                    if (op_take && op_want) begin
                        st_r <= TR_MARK;
                        sh_r <= op_event_in.data;
                        cnt_r <= op_nibbles(op_event_in.size);
                        mark_r <= op_mark;
                    end else if (br_take && branch_sel != 2'h0) begin
                        st_r <= TR_SHIFT;
                        sh_r <= br_target_in;
                        cnt_r <= branch_nibbles(branch_sel);
                    end
                end
                TR_MARK: begin
                    trace_data_pins_out <= mark_r;
                    st_r <= TR_SHIFT;
                end
                TR_SHIFT: begin
                    trace_data_pins_out <= sh_r[3:0];
                    sh_r <= {4'h0, sh_r[31:4]};
                    cnt_r <= cnt_r - 4'h1;
                    if (cnt_r == 4'h1) begin
                        st_r <= TR_IDLE;
                    end
                end
                default: st_r <= TR_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    emu_follows_write_a: assert property (
        ce_in && bdp_wr_in |=> force_emulator_entry_out ==
            $past(bdp_wdata_in[`FLD_FORCE_EMU]))
        else $error("emulator entry does not follow debug write");
    reserved_zero_a: assert property (
        (cfg_r & ~`DBG_CFG_WMASK) == 32'h0000_0000)
        else $error("reserved bits held nonzero");
    no_capture_a: assert property (
        idle && pst_tick && ce_in && op_valid_in && capture_sel == 2'h0
        |=> st_r == TR_IDLE)
        else $error("operand shown with capture off");
    user_halt_a: assert property (
        halt_instr_in && user_mode_in && !cfg_r[`FLD_USER_HALT]
        |-> !halt_allowed_out)
        else $error("user halt allowed while not permitted");
    serial_gap_a: assert property (
        ce_in && serial_on && instr_done_in |=> issue_hold_out [*5])
        else $error("serial gap shorter than five cycles");
    pc_hit_hold_a: assert property (
        pc_bkpt_hit_in |-> issue_hold_out ##1
            (bkpt_report_out || !$past(ce_in)))
        else $error("pc breakpoint not held and reported");
    irq_ignore_a: assert property (
        step_on && cfg_r[`FLD_IRQ_IGNORE] |-> !irq_take_out)
        else $error("interrupt taken while ignored in step");
    step_halt_a: assert property (
        ce_in && step_on && instr_done_in |=> core_halt_out)
        else $error("no halt after stepped instruction");
    sup_no_read_a: assert property (
        !bdp_rd_in |=> $stable(bdp_rdata_out))
        else $error("read data changed without debug read");

    step_go_c: cover property (core_halt_out ##1 bdp_go_in ##1 !core_halt_out);
    op_shown_c: cover property (st_r == TR_MARK ##[1:4] st_r == TR_SHIFT);
    br_shown_c: cover property (br_take && branch_sel == 2'h3);
    serial_c: cover property (serial_on && instr_done_in);

endmodule // debug_config_lower_controls

// ### pkg/debug_config_cfg.svh
// Offsets, field positions, reset values and timing counts of debug config
`ifndef DEBUG_CONFIG_CFG_SVH
`define DEBUG_CONFIG_CFG_SVH

// Debug control register number; neither access path decodes it
`define DBG_CFG_REG_NUM 8'h00
// Field positions in the lower half of the register
`define FLD_FORCE_EMU 13
`define FLD_CAPTURE_HI 12
`define FLD_CAPTURE_LO 11
`define FLD_USER_HALT 10
`define FLD_BRANCH_HI 9
`define FLD_BRANCH_LO 8
`define FLD_SERIAL 6
`define FLD_IRQ_IGNORE 5
`define FLD_SINGLE_STEP 4
// Writable bits; reserved bits 7 and 3..0 always hold zero
`define DBG_CFG_WMASK 32'h0000_3f70
`define DBG_CFG_RESET 32'h0000_0000
// Extra cycles added per instruction in serial execution
`define SERIAL_GAP_CYCLES 3'h5
// Last count of the status clock divider; a status clock period is this count plus one processor cycles
`define PST_DIV 1'h1
// Size marks sent on the trace pins ahead of operand data
`define TRACE_MARK_BYTE 4'h8
`define TRACE_MARK_WORD 4'h9
`define TRACE_MARK_LONG 4'ha

`endif

// ### pkg/debug_config_pkg.sv
// Types shared by the debug configuration block
package debug_config_pkg;

    typedef enum logic [1:0] {
        SIZE_BYTE,
        SIZE_WORD,
        SIZE_LONG,
        SIZE_RSVD
    } op_size_t;

    typedef struct packed {
        logic is_write;
        op_size_t size;
        logic [31:0] data;
    } operand_event_t;

    typedef enum logic [1:0] {
        TR_IDLE,
        TR_MARK,
        TR_SHIFT
    } trace_state_t;

endpackage

// ### testbench/debug_host_model.sv
// Model of the development system on the background debug port
`timescale 1ns/1ps

module debug_host_model (
    input wire logic clk_in,
    input wire logic [31:0] rdata_in,
    output logic wr_out,
    output logic rd_out,
    output logic [31:0] wdata_out,
    output logic go_out
);
    // ====================
    // Port commands
    initial begin
        {wr_out, rd_out, go_out} = 3'h0;
        wdata_out = 32'h0;
    end

    task automatic wr(input logic [31:0] d);
        @(posedge clk_in);
        #1;
        wr_out = 1'b1;
        wdata_out = d & 32'h0000_3f70;
        @(posedge clk_in);
        #1;
        wr_out = 1'b0;
        // Stale data inverted so it is never mistaken for valid
        wdata_out = ~wdata_out;
    endtask

    task automatic rd(output logic [31:0] d);
        @(posedge clk_in);
        #1;
        rd_out = 1'b1;
        @(posedge clk_in);
        #1;
        rd_out = 1'b0;
        d = rdata_in;
    endtask

    task automatic go();
        @(posedge clk_in);
        #1;
        go_out = 1'b1;
        @(posedge clk_in);
        #1;
        go_out = 1'b0;
    endtask
endmodule // debug_host_model

// ### testbench/debug_config_lower_controls_test.sv
// Self-checking bench for the debug configuration lower controls
`timescale 1ns/1ps

module debug_config_lower_controls_test;
    import debug_config_pkg::*;
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    mismatches++; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); \
    end end
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic sup_wr_in, bdp_wr_in, bdp_rd_in, bdp_go_in;
    logic [31:0] sup_wdata_in, bdp_wdata_in, bdp_rdata_out, br_target_in;
    logic instr_done_in, user_mode_in, halt_instr_in, irq_pending_in;
    logic pc_bkpt_hit_in, data_bkpt_hit_in, op_valid_in, br_valid_in;
    logic force_emulator_entry_out, serial_execution_mode_out;
    logic core_halt_out, issue_hold_out, halt_allowed_out, irq_take_out;
    logic bkpt_report_out, op_ready_out, br_ready_out;
    logic processor_status_clock_out;
    logic [3:0] trace_data_pins_out;
    operand_event_t op_event_in;
    logic [31:0] d;
    int mismatches = 0;
    int checks_done = 0;

    always #12.5 clk_in = ~clk_in;

    debug_config_lower_controls dut_u (.clk_in, .rst_in, .ce_in,
        .sup_wr_in, .sup_wdata_in, .bdp_wr_in, .bdp_rd_in, .bdp_wdata_in,
        .bdp_go_in, .bdp_rdata_out, .instr_done_in, .user_mode_in,
        .halt_instr_in, .irq_pending_in, .pc_bkpt_hit_in, .data_bkpt_hit_in,
        .force_emulator_entry_out, .serial_execution_mode_out,
        .core_halt_out, .issue_hold_out, .halt_allowed_out, .irq_take_out,
        .bkpt_report_out, .op_valid_in, .op_event_in, .op_ready_out,
        .br_valid_in, .br_target_in, .br_ready_out, .trace_data_pins_out,
        .processor_status_clock_out);

    debug_host_model host (.clk_in(clk_in), .rdata_in(bdp_rdata_out),
        .wr_out(bdp_wr_in), .rd_out(bdp_rd_in), .wdata_out(bdp_wdata_in),
        .go_out(bdp_go_in));

    // ====================
    // Helpers
    task automatic stop_test();
        if (mismatches == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic step();
        @(posedge clk_in);
        #1;
    endtask

    task automatic done();
        instr_done_in = 1'b1;
        step();
        instr_done_in = 1'b0;
    endtask

    // Offer one event, then follow its nibbles on the trace pins
    task automatic trace(input logic br, input logic w, input logic [1:0] sz,
                         input logic [31:0] v, input logic [35:0] e,
                         input int n);
        int i;
        op_event_in = {w, sz, v};
        br_target_in = v;
        if (br) br_valid_in = 1'b1;
        else op_valid_in = 1'b1;
        i = 0;
        do begin
            @(negedge clk_in);
            i++;
        end while ((br ? br_ready_out : op_ready_out) !== 1'b1 && i < 40);
        if (i >= 40) begin
            mismatches++;
            stop_test();
        end
        step();
        {op_valid_in, br_valid_in} = 2'h0;
        for (i = 0; i <= n; i++) begin
            repeat (2) @(posedge clk_in);
            #1;
            `CHK(trace_data_pins_out, i < n ? e[4*i+:4] : 4'h0)
        end
    endtask

    // ====================
    // Scenarios
    task automatic t_regs();
        `CHK(core_halt_out, 1'b0)
        `CHK(force_emulator_entry_out, 1'b0)
        host.rd(d);
        `CHK(d, 32'h0)
        host.wr(32'hffff_ffff);
        `CHK(force_emulator_entry_out, 1'b1)
        `CHK(serial_execution_mode_out, 1'b1)
        host.rd(d);
        `CHK(d, 32'h0000_3f70)
        sup_wr_in = 1'b1;
        sup_wdata_in = 32'h0000_0040;
        step();
        sup_wr_in = 1'b0;
        `CHK(force_emulator_entry_out, 1'b0)
        host.rd(d);
        `CHK(d, 32'h0000_0040)
    endtask

    task automatic t_serial();
        int i;
        done();
        for (i = 0; i < 5; i++) begin
            `CHK(issue_hold_out, 1'b1)
            step();
        end
        `CHK(issue_hold_out, 1'b0)
        data_bkpt_hit_in = 1'b1;
        // Let the combinational stall settle before looking
        #1;
        `CHK(issue_hold_out, 1'b1)
        step();
        data_bkpt_hit_in = 1'b0;
        `CHK(issue_hold_out, 1'b1)
        `CHK(bkpt_report_out, 1'b1)
        host.wr(32'h0);
        pc_bkpt_hit_in = 1'b1;
        #1;
        `CHK(issue_hold_out, 1'b1)
        step();
        pc_bkpt_hit_in = 1'b0;
        `CHK(bkpt_report_out, 1'b1)
        data_bkpt_hit_in = 1'b1;
        #1;
        `CHK(issue_hold_out, 1'b0)
        step();
        data_bkpt_hit_in = 1'b0;
        `CHK(bkpt_report_out, 1'b1)
    endtask

    task automatic t_step_halt();
        halt_instr_in = 1'b1;
        #1;
        `CHK(halt_allowed_out, 1'b1)
        user_mode_in = 1'b1;
        #1;
        `CHK(halt_allowed_out, 1'b0)
        host.wr(32'h400);
        `CHK(halt_allowed_out, 1'b1)
        host.wr(32'h30);
        irq_pending_in = 1'b1;
        #1;
        `CHK(irq_take_out, 1'b0)
        host.wr(32'h10);
        `CHK(irq_take_out, 1'b1)
        irq_pending_in = 1'b0;
        #1;
        `CHK(irq_take_out, 1'b0)
        host.go();
        `CHK(core_halt_out, 1'b0)
        done();
        `CHK(core_halt_out, 1'b1)
        `CHK(issue_hold_out, 1'b1)
        host.go();
        `CHK(core_halt_out, 1'b0)
        done();
        host.wr(32'h0);
        // Halt drops one cycle after the step bit is cleared
        step();
        `CHK(core_halt_out, 1'b0)
    endtask

    task automatic t_trace();
        int m;
        int w;
        for (m = 0; m < 4; m++) begin
            host.wr(32'(m) << 11);
            for (w = 0; w < 2; w++)
                trace(0, w[0], 2'h0, 32'h5a, 36'h5a8,
                      (w ? m[0] : m[1]) ? 3 : 0);
            host.wr(32'(m) << 8);
            trace(1, 0, 2'h0, 32'h8765_4321, 36'h8765_4321,
                  m ? 2 * m + 2 : 0);
        end
        host.wr(32'h1800);
        trace(0, 1, 2'h1, 32'h1234, 36'h1_2349, 5);
        trace(0, 0, 2'h2, 32'h89ab_cdef, {32'h89ab_cdef, 4'ha}, 9);
    endtask

    // Frozen clock enable, then a reset in mid-run with the core halted
    task automatic t_freeze();
        host.wr(32'h0000_2050);
        ce_in = 1'b0;
        host.wr(32'h0);
        done();
        `CHK(force_emulator_entry_out, 1'b1)
        `CHK(core_halt_out, 1'b0)
        ce_in = 1'b1;
        done();
        `CHK(core_halt_out, 1'b1)
        rst_in = 1'b1;
        step();
        rst_in = 1'b0;
        `CHK(core_halt_out, 1'b0)
        `CHK(force_emulator_entry_out, 1'b0)
        `CHK(serial_execution_mode_out, 1'b0)
        host.rd(d);
        `CHK(d, 32'h0)
    endtask

    initial begin
        {sup_wr_in, instr_done_in, user_mode_in, halt_instr_in} = 4'h0;
        {irq_pending_in, pc_bkpt_hit_in, data_bkpt_hit_in} = 3'h0;
        {op_valid_in, br_valid_in} = 2'h0;
        {sup_wdata_in, br_target_in} = 64'h0;
        op_event_in = '0;
        repeat (16) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        t_regs();
        t_serial();
        t_step_halt();
        t_trace();
        t_freeze();
        stop_test();
    end
endmodule // debug_config_lower_controls_test
